// *** hw/flash_prot_pkg.sv ***
// Notes on behaviour
// - 96 KB array, whole range decoded
// - 1 KB blocks erase independently
// - erased block reads back all ones
// - protection held per 2 KB region
// - read-only region refuses erase and program
// - execute-only region serves instruction fetch only
package flash_prot_pkg;

  localparam int FLASH_BYTES = 98304;
  localparam int WORD_BYTES = 4;
  localparam int WORDS_N = FLASH_BYTES / WORD_BYTES;
  localparam int BLOCK_BYTES = 1024;
  localparam int REGION_BYTES = 2048;
  localparam int REGIONS_N = FLASH_BYTES / REGION_BYTES;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 32;
  localparam int WIDX_W = 15;
  localparam int REGION_W = 6;
  localparam int BLOCK_W = 7;
  localparam int BOFF_W = 8;

  // byte address field positions
  localparam int WIDX_LSB = 2;
  localparam int BLOCK_LSB = 10;
  localparam int REGION_LSB = 11;

  localparam logic [WIDX_W-1:0] FLASH_WORDS = 15'h6000;
  localparam logic [BOFF_W-1:0] BLOCK_LAST = 8'hFF;
  localparam logic [BOFF_W-1:0] BLOCK_FIRST = 8'h00;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;

  // erase takes one cycle per word after the accepting edge
  localparam int ERASE_CYCLES = BLOCK_BYTES / WORD_BYTES;

  typedef enum logic [1:0] {
    KIND_FETCH = 2'h0,
    KIND_READ = 2'h1,
    KIND_PROG = 2'h2,
    KIND_ERASE = 2'h3
  } access_kind_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_ERASE = 2'h2
  } ctrl_state_t;

endpackage : flash_prot_pkg

// *** hw/prot_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface prot_if;
  import flash_prot_pkg::*;
  access_kind_t kind;
  logic debug;
  logic [REGION_W-1:0] region;
  logic allow;
  logic ro;
  logic xo;

  modport requester (output kind, output debug, output region, input allow, input ro, input xo);
  modport gate (input kind, input debug, input region, output allow, output ro, output xo);
endinterface : prot_if
`default_nettype wire

// *** hw/prot_check.sv ***
`timescale 1ns/1ps
`default_nettype none
module prot_check
  import flash_prot_pkg::*;
(
  input wire logic [REGIONS_N-1:0] prot_ro_i,
  input wire logic [REGIONS_N-1:0] prot_xo_i,
  prot_if.gate pif
);

  wire logic sel_ro;
  wire logic sel_xo;
  wire logic is_modify;
  wire logic is_data_read;

  // regions past the array come out allowed here; the caller masks them with in_range
  assign sel_ro = (pif.region < REGION_W'(REGIONS_N)) ? prot_ro_i[pif.region] : 1'b0;
  assign sel_xo = (pif.region < REGION_W'(REGIONS_N)) ? prot_xo_i[pif.region] : 1'b0;
  assign is_modify = (pif.kind == KIND_PROG) || (pif.kind == KIND_ERASE);
  // the debugger never counts as instruction fetch, whatever kind it claims
  assign is_data_read = (pif.kind == KIND_READ) || pif.debug;

  assign pif.ro = sel_ro;
  assign pif.xo = sel_xo;
  assign pif.allow = !((sel_ro || sel_xo) && is_modify)
                  && !(sel_xo && is_data_read);

endmodule : prot_check
`default_nettype wire

// *** hw/flash_block_protection.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_block_protection
  import flash_prot_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic req_valid_i,
  input wire logic [1:0] req_kind_i,
  input wire logic req_debug_i,
  input wire logic [ADDR_W-1:0] req_addr_i,
  input wire logic [DATA_W-1:0] req_wdata_i,
  input wire logic [REGIONS_N-1:0] prot_ro_i,
  input wire logic [REGIONS_N-1:0] prot_xo_i,
  input wire logic viol_clr_i,
  output logic req_ready_o,
  output logic resp_valid_o,
  output logic resp_denied_o,
  output logic [DATA_W-1:0] resp_rdata_o,
  output logic viol_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  prot_if pif ();

  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [BLOCK_W-1:0] erase_block;
  logic [BOFF_W-1:0] erase_cnt;
  logic [DATA_W-1:0] mem [0:WORDS_N-1];

  wire access_kind_t kind;
  wire logic [WIDX_W-1:0] word_idx;
  wire logic [BLOCK_W-1:0] block_idx;
  wire logic in_range;
  wire logic accept;
  wire logic ok;
  wire logic is_read;
  wire logic is_prog;
  wire logic is_erase;
  wire logic erase_start;
  wire logic erase_last;
  wire logic prog_we;
  wire logic erase_we;
  wire logic [WIDX_W-1:0] erase_idx;
  wire logic resp_now;
  wire logic set_viol;

  assign kind = access_kind_t'(req_kind_i);
  assign word_idx = req_addr_i[ADDR_W-1:WIDX_LSB];
  assign block_idx = req_addr_i[ADDR_W-1:BLOCK_LSB];
  assign in_range = word_idx < FLASH_WORDS;

  assign pif.kind = kind;
  assign pif.debug = req_debug_i;
  assign pif.region = req_addr_i[ADDR_W-1:REGION_LSB];

  prot_check u_check (
    .prot_ro_i (prot_ro_i),
    .prot_xo_i (prot_xo_i),
    .pif (pif)
  );

  // one request in flight at a time; erase holds the port off
  assign req_ready_o = (state == ST_IDLE);
  assign accept = req_valid_i && req_ready_o;
  assign ok = in_range && pif.allow;
  assign is_read = (kind == KIND_FETCH) || (kind == KIND_READ);
  assign is_prog = (kind == KIND_PROG);
  assign is_erase = (kind == KIND_ERASE);

  assign erase_start = accept && is_erase && ok;
  assign erase_last = (state == ST_ERASE) && (erase_cnt == BLOCK_LAST);
  assign prog_we = accept && is_prog && ok;
  assign erase_we = (state == ST_ERASE);
  assign erase_idx = {erase_block, erase_cnt};
  // a refused erase answers at once; a granted one answers when the sweep ends
  assign resp_now = (accept && !(is_erase && ok)) || erase_last;
  assign set_viol = accept && !ok;

  ////////////////////////////////////////////////////////////////////////////
  // control

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (erase_start) begin
          next_state = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (erase_last) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      erase_block <= '0;
      erase_cnt <= BLOCK_FIRST;
    end else if (erase_start) begin
      erase_block <= block_idx;
      erase_cnt <= BLOCK_FIRST;
    end else if (erase_we) begin
      erase_cnt <= erase_cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_denied_o <= 1'b0;
    end else begin
      resp_valid_o <= resp_now;
      resp_denied_o <= set_viol;
    end
  end

  // refused or out-of-range reads return zero so protected data never leaks
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      resp_rdata_o <= ZERO_WORD;
    end else if (accept) begin
      resp_rdata_o <= (is_read && ok) ? mem[word_idx] : ZERO_WORD;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      viol_flag_o <= 1'b0;
    end else if (set_viol) begin
      viol_flag_o <= 1'b1;
    end else if (viol_clr_i) begin
      viol_flag_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // array

  // contents are non-volatile, so the array takes no reset
  // programming can only clear bits, as a real cell would
  always_ff @(posedge clk_i) begin
    if (erase_we) begin
      mem[erase_idx] <= ERASED_WORD;
    end else if (prog_we) begin
      mem[word_idx] <= mem[word_idx] & req_wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic [WIDX_W-1:0] chk_idx;
  logic [DATA_W-1:0] chk_val;
  logic chk_arm;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chk_arm <= 1'b0;
      chk_idx <= '0;
      chk_val <= ZERO_WORD;
    end else begin
      chk_arm <= accept && is_prog && in_range && !ok;
      chk_idx <= word_idx;
      chk_val <= in_range ? mem[word_idx] : ZERO_WORD;
    end
  end

  range_decode_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && !in_range |=> resp_valid_o && resp_denied_o)
    else $error("out-of-range access not refused");

  erase_time_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    erase_start |=> !req_ready_o [*8] ##248 !resp_valid_o ##1 resp_valid_o && !resp_denied_o)
    else $error("erase answer not after one block sweep");

  erase_ones_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    erase_last |=> mem[{erase_block, BLOCK_FIRST}] == ERASED_WORD
               && mem[{erase_block, BLOCK_LAST}] == ERASED_WORD)
    else $error("erased block not all ones");

  region_free_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && in_range && !pif.ro && !pif.xo |=> !resp_denied_o)
    else $error("unprotected region refused");

  ro_modify_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && pif.ro && (is_prog || is_erase) |=> resp_denied_o && req_ready_o)
    else $error("read-only region modified");

  denied_keep_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    chk_arm |-> mem[chk_idx] == chk_val)
    else $error("refused program changed the array");

  xo_data_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    accept && in_range && pif.xo |=> resp_denied_o == (kind != KIND_FETCH || req_debug_i))
    else $error("execute-only gating wrong");

  xo_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    resp_valid_o && resp_denied_o |-> resp_rdata_o == ZERO_WORD)
    else $error("refused read returned data");

  viol_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    set_viol |=> resp_valid_o && viol_flag_o)
    else $error("violation not flagged");

endmodule : flash_block_protection
`default_nettype wire

// *** testbench/flash_requester.sv ***
`timescale 1ns/1ps
`default_nettype none
module flash_requester
  import flash_prot_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic rvalid_i,
  input wire logic denied_i,
  input wire logic [DATA_W-1:0] rdata_i,
  output var logic valid_o,
  output var logic [1:0] kind_o,
  output var logic debug_o,
  output var logic [ADDR_W-1:0] addr_o,
  output var logic [DATA_W-1:0] wdata_o
);
  initial begin
    valid_o = 1'b0;
    kind_o = 2'h0;
    debug_o = 1'b0;
    addr_o = '0;
    wdata_o = '0;
  end

  // released address and data lines show the inverse so a stale value is never mistaken for a live one
  task automatic xfer(input logic [1:0] k, input logic d, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] w, output logic dn, output logic [DATA_W-1:0] rd,
                      output int lat);
    int n;
    @(negedge clk_i);
    valid_o = 1'b1;
    kind_o = k;
    debug_o = d;
    addr_o = a;
    wdata_o = w;
    // ready only moves on a rising edge, so its level here is what the next rising edge samples
    while (ready_i !== 1'b1) @(negedge clk_i);
    @(posedge clk_i);
    @(negedge clk_i);
    valid_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~w;
    n = 0;
    while (rvalid_i !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    lat = n;
    if (rvalid_i === 1'b1) begin
      dn = denied_i;
      rd = rdata_i;
    end else begin
      // no answer: poison both so the caller's compares count it
      dn = 1'bx;
      rd = 'x;
    end
  endtask : xfer
endmodule : flash_requester
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb_top;
  import flash_prot_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic clr = 1'b0;
  logic [REGIONS_N-1:0] ro = '0;
  logic [REGIONS_N-1:0] xo = '0;
  wire logic valid, debug, ready, rvalid, denied, viol;
  wire logic [1:0] kind;
  wire logic [ADDR_W-1:0] addr;
  wire logic [DATA_W-1:0] wdata, rdata;
  logic [15:0] rnd = 16'h005D;
  logic [15:0] ra;
  logic [DATA_W-1:0] mem [int];
  logic exp_viol = 1'b0;
  int fail_count = 0;
  int checked = 0;

  always #5 clk_i = ~clk_i;

  flash_block_protection flash_block_protection_inst (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .req_valid_i(valid), .req_kind_i(kind), .req_debug_i(debug), .req_addr_i(addr),
    .req_wdata_i(wdata), .prot_ro_i(ro), .prot_xo_i(xo), .viol_clr_i(clr),
    .req_ready_o(ready), .resp_valid_o(rvalid), .resp_denied_o(denied),
    .resp_rdata_o(rdata), .viol_flag_o(viol));

  flash_requester flash_requester_inst (.clk_i(clk_i), .ready_i(ready), .rvalid_i(rvalid),
    .denied_i(denied), .rdata_i(rdata), .valid_o(valid), .kind_o(kind), .debug_o(debug),
    .addr_o(addr), .wdata_o(wdata));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic report_and_stop;
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  ////////////////////////////////////////////////////////////////
  task automatic op(input logic [1:0] k, input logic d, input logic [ADDR_W-1:0] a);
    logic dn, xden;
    logic [DATA_W-1:0] rd, w, xrd;
    int wi, r, lat, xlat;
    rnd = lfsr(rnd);
    w = {rnd, ~rnd};
    wi = int'(a[16:2]);
    r = int'(a[16:11]);
    // out-of-range indexes past the protection vector give x, but the range term already wins
    xden = (a[16:2] >= FLASH_WORDS) || (k >= 2'h2 && (ro[r] || xo[r])) || (xo[r] && (k == 2'h1 || d));
    flash_requester_inst.xfer(k, d, a, w, dn, rd, lat);
    xrd = '0;
    xlat = (!xden && k == 2'h3) ? ERASE_CYCLES : 0;
    if (!xden && k == 2'h3) for (int i = 0; i < 256; i++) mem[int'(a[16:10]) * 256 + i] = ERASED_WORD;
    if (!xden && k == 2'h2) mem[wi] = mem[wi] & w;
    if (!xden && k <= 2'h1) xrd = mem[wi];
    exp_viol = exp_viol | xden;
    `CHK("denied", xden, dn)
    `CHK("rdata", xrd, rd)
    `CHK("latency", xlat, lat)
    `CHK("viol", exp_viol, viol)
    if (rnd[3]) begin
      @(negedge clk_i);
      clr = 1'b1;
      @(negedge clk_i);
      clr = 1'b0;
      exp_viol = 1'b0;
      `CHK("viol_clr", exp_viol, viol)
    end
  endtask : op

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    arst_n_i = 1'b1;
    for (int b = 0; b < 4; b++) op(2'h3, 1'b0, ADDR_W'(b * 1024));
    op(2'h3, 1'b0, 17'h17C00);
    op(2'h1, 1'b1, 17'h17FFC);
    op(2'h0, 1'b0, 17'h18000);
    // random traffic stays in the four erased blocks so every read has a known model value
    for (int j = 0; j < 300; j++) begin
      rnd = lfsr(rnd);
      ro[1:0] = rnd[1:0] & rnd[3:2];
      xo[1:0] = rnd[5:4] & rnd[7:6];
      ra = lfsr(rnd);
      op(rnd[9:8], rnd[10], {5'h00, ra[11:0]});
    end
    report_and_stop();
  end

  initial begin
    // the run needs about 13k cycles, mostly erase sweeps; allow nearly four times that
    #500000;
    fail_count++;
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
